// File: rtl/dspwm_timer.sv
// Behaviour
// - fixed TOP modes mask compare bits above resolution on write
// - phase correct mode loads compare buffers at TOP
// - output mode 10 gives non-inverted, 11 inverted dual-slope PWM
// - pin shows waveform only when its direction bit selects output
// - match counting up sets or clears; counting down does the opposite
// - timer clock is I/O clock over 1, 8, 64, 256 or 1024
// - non-inverted compare at BOTTOM gives constant low, at TOP constant high; inverted gives the opposite
// - phase correct mode 11 with channel A mode 01 toggles A
// - modes 8 and 9 are frequency correct, TOP from capture or A
// - counter runs up from 0x0000 to TOP then back down
// - non-inverting clears on up match, sets on down match
// - TOP lies between 0x0003 and the 16-bit maximum
// - count holds TOP for one timer clock then turns down
// - compare flag sets when counter equals active compare value
// - frequency correct mode sets overflow at BOTTOM with buffer load
// - TOP from A or capture sets that flag when counter hits TOP
// - frequency correct mode loads buffers at BOTTOM, slopes symmetric
// - frequency correct mode 9 with channel A mode 01 toggles A
// - capture TOP register is unbuffered, writes act at once
// - phase correct modes are 1, 2, 3, 10 and 11
// - modes 1-3 use 0x00FF, 0x01FF, 0x03FF; 10 capture, 11 A
// - phase correct sets overflow at BOTTOM, loads buffers at TOP
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "dspwm_regs.svh"
`default_nettype none

module dspwm_timer (
   // clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         rst,
   // apb slave
   input  wire dspwm_pkg::dspwm_apb_req_type apb_req,
   output var  dspwm_pkg::dspwm_apb_rsp_type apb_rsp,
   // compare output pins
   output var  dspwm_pkg::dspwm_pins_type    pins
);

   dspwm_pkg::dspwm_state_type st_q;
   dspwm_pkg::dspwm_state_type st_d;

   logic        tick;
   logic        dual;
   logic        pc_mode;
   logic        pfc_mode;
   logic [15:0] top;
   logic        at_top;
   logic        at_bot;
   logic        up_act;
   logic        match_a;
   logic        match_b;
   logic        toggle_ok;
   logic        setup;
   logic        access;
   logic        wr;
   logic [11:0] ofs;

   function automatic logic is_pc(input logic [3:0] w);
      is_pc = (w == `DSPWM_WAVE_PC_8) || (w == `DSPWM_WAVE_PC_9) ||
              (w == `DSPWM_WAVE_PC_10) || (w == `DSPWM_WAVE_PC_CAP) ||
              (w == `DSPWM_WAVE_PC_CMPA);
   endfunction

   function automatic logic is_pfc(input logic [3:0] w);
      is_pfc = (w == `DSPWM_WAVE_PFC_CAP) ||
               (w == `DSPWM_WAVE_PFC_CMPA);
   endfunction

   function automatic logic top_is_cap(input logic [3:0] w);
      top_is_cap = (w == `DSPWM_WAVE_PFC_CAP) || (w == `DSPWM_WAVE_PC_CAP);
   endfunction

   function automatic logic top_is_cmpa(input logic [3:0] w);
      top_is_cmpa = (w == `DSPWM_WAVE_PFC_CMPA) ||
                    (w == `DSPWM_WAVE_PC_CMPA);
   endfunction

   // all-ones mask of the active resolution, full width when not fixed
   function automatic logic [15:0] fixed_mask(input logic [3:0] w);
      unique case (w)
         `DSPWM_WAVE_PC_8:  fixed_mask = `DSPWM_TOP_8;
         `DSPWM_WAVE_PC_9:  fixed_mask = `DSPWM_TOP_9;
         `DSPWM_WAVE_PC_10: fixed_mask = `DSPWM_TOP_10;
         default:           fixed_mask = `DSPWM_TOP_MAX;
      endcase
   endfunction

   function automatic logic [9:0] presc_mask(input logic [2:0] cs);
      unique case (cs)
         `DSPWM_CS_DIV8:    presc_mask = `DSPWM_MASK_DIV8;
         `DSPWM_CS_DIV64:   presc_mask = `DSPWM_MASK_DIV64;
         `DSPWM_CS_DIV256:  presc_mask = `DSPWM_MASK_DIV256;
         `DSPWM_CS_DIV1024: presc_mask = `DSPWM_MASK_DIV1024;
         default:           presc_mask = `DSPWM_MASK_DIV1;
      endcase
   endfunction

   // next compare output level on one channel
   function automatic logic next_out(input logic       cur,
                                     input logic [1:0] mode,
                                     input logic       match,
                                     input logic       up_dir,
                                     input logic       tgl);
      next_out = cur;
      if (match) begin
         unique case (mode)
            `DSPWM_COM_TOGGLE: next_out = tgl ? ~cur : cur;
            `DSPWM_COM_NONINV: next_out = ~up_dir;
            `DSPWM_COM_INV:    next_out = up_dir;
            default:           next_out = cur;
         endcase
      end
   endfunction

   function automatic logic connected(input logic [1:0] mode,
                                      input logic       tgl);
      connected = (mode == `DSPWM_COM_NONINV) ||
                  (mode == `DSPWM_COM_INV) ||
                  ((mode == `DSPWM_COM_TOGGLE) && tgl);
   endfunction

   // stopped select never ticks; /1 ticks every cycle
   assign tick = (st_q.ctrl.clk_sel != `DSPWM_CS_STOP) &&
                 ((st_q.presc & presc_mask(st_q.ctrl.clk_sel)) ==
                  presc_mask(st_q.ctrl.clk_sel));

   assign pc_mode   = is_pc(st_q.ctrl.wave);
   assign pfc_mode  = is_pfc(st_q.ctrl.wave);
   assign dual      = pc_mode || pfc_mode;
   assign toggle_ok = top_is_cmpa(st_q.ctrl.wave);

   // register tops below two bits are raised to the minimum
   always_comb begin
      top = fixed_mask(st_q.ctrl.wave);
      if (top_is_cap(st_q.ctrl.wave)) begin
         top = st_q.cap_top;
      end else if (top_is_cmpa(st_q.ctrl.wave)) begin
         top = st_q.cmp_a;
      end
      if (top < `DSPWM_TOP_MIN) begin
         top = `DSPWM_TOP_MIN;
      end
   end

   assign at_top  = (st_q.cnt == top);
   assign at_bot  = (st_q.cnt == `DSPWM_BOTTOM);
   // match at TOP acts as down match and at BOTTOM as up match, which
   // makes non-inverted compare == TOP steady high and compare == BOTTOM steady low
   assign up_act  = at_top ? 1'b0 : (at_bot ? 1'b1 : st_q.up);
   assign match_a = tick && dual && (st_q.cnt == st_q.cmp_a);
   assign match_b = tick && dual && (st_q.cnt == st_q.cmp_b);

   assign setup  = apb_req.psel && !apb_req.penable;
   assign access = apb_req.psel && apb_req.penable && st_q.rsp.pready;
   assign wr     = access && apb_req.pwrite && !st_q.rsp.pslverr;
   assign ofs    = apb_req.paddr[11:0];

   always_comb begin
      st_d = st_q;

      if (st_q.ctrl.clk_sel == `DSPWM_CS_STOP) begin
         st_d.presc = '0;
      end else begin
         st_d.presc = st_q.presc + 10'h001;
      end

      if (!dual) begin
         // other waveform modes are not built here: counter parks
         st_d.cnt = `DSPWM_BOTTOM;
         st_d.up  = 1'b1;
      end else if (tick) begin
         if (st_q.up) begin
            if (at_top) begin
               st_d.cnt = top - 16'h0001;
               st_d.up  = 1'b0;
            end else begin
               st_d.cnt = st_q.cnt + 16'h0001;
            end
         end else if (at_bot) begin
            st_d.cnt = st_q.cnt + 16'h0001;
            st_d.up  = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt - 16'h0001;
         end

         if ((pc_mode && at_top) || (pfc_mode && at_bot)) begin
            st_d.cmp_a = st_q.buf_a;
            st_d.cmp_b = st_q.buf_b;
         end
      end

      st_d.pins.a_out = next_out(st_q.pins.a_out, st_q.ctrl.mode_a,
                                 match_a, up_act, toggle_ok);
      st_d.pins.b_out = next_out(st_q.pins.b_out, st_q.ctrl.mode_b,
                                 match_b, up_act, 1'b0);
      st_d.pins.a_oe  = st_q.ctrl.dir_a &&
                        connected(st_q.ctrl.mode_a, toggle_ok);
      st_d.pins.b_oe  = st_q.ctrl.dir_b &&
                        connected(st_q.ctrl.mode_b, 1'b0);

      // write one to clear; a set in the same cycle wins
      if (wr && (ofs == `DSPWM_FLAGS_OFS)) begin
         st_d.flags = st_q.flags &
                      ~apb_req.pwdata[`DSPWM_FLAGS_W-1:0];
      end
      if (tick && dual && at_bot) begin
         st_d.flags.ovf = 1'b1;
      end
      if (match_a || (tick && dual && at_top && toggle_ok)) begin
         st_d.flags.cmp_a = 1'b1;
      end
      if (match_b) begin
         st_d.flags.cmp_b = 1'b1;
      end
      if (tick && dual && at_top && top_is_cap(st_q.ctrl.wave)) begin
         st_d.flags.cap = 1'b1;
      end

      if (wr) begin
         unique case (ofs)
            `DSPWM_CTRL_OFS:
               st_d.ctrl = apb_req.pwdata[`DSPWM_CTRL_W-1:0];
            `DSPWM_CMP_A_OFS:
               st_d.buf_a = apb_req.pwdata[15:0] &
                            fixed_mask(st_q.ctrl.wave);
            `DSPWM_CMP_B_OFS:
               st_d.buf_b = apb_req.pwdata[15:0] &
                            fixed_mask(st_q.ctrl.wave);
            `DSPWM_CAP_TOP_OFS:
               st_d.cap_top = apb_req.pwdata[15:0];
            default: ;
         endcase
      end

      // answer is prepared in setup and shown through the access phase
      st_d.rsp.pready  = setup;
      st_d.rsp.pslverr = 1'b0;
      st_d.rsp.prdata  = '0;
      if (setup) begin
         unique case (ofs)
            `DSPWM_CTRL_OFS:    st_d.rsp.prdata = {19'h0, st_q.ctrl};
            `DSPWM_COUNT_OFS:   st_d.rsp.prdata = {16'h0, st_q.cnt};
            `DSPWM_CMP_A_OFS:   st_d.rsp.prdata = {16'h0, st_q.buf_a};
            `DSPWM_CMP_B_OFS:   st_d.rsp.prdata = {16'h0, st_q.buf_b};
            `DSPWM_CAP_TOP_OFS: st_d.rsp.prdata = {16'h0, st_q.cap_top};
            `DSPWM_FLAGS_OFS:   st_d.rsp.prdata = {28'h0, st_q.flags};
            `DSPWM_STATUS_OFS:
               st_d.rsp.prdata = {29'h0, st_q.pins.b_out,
                                  st_q.pins.a_out, st_q.up};
            default:            st_d.rsp.pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q      <= '0;
         st_q.up   <= 1'b1;
         st_q.ctrl <= `DSPWM_CTRL_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign apb_rsp = st_q.rsp;
   assign pins    = st_q.pins;

   default clocking dflt_cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence up_at_top_s;
      tick && dual && st_q.up && at_top;
   endsequence

   sequence turn_down_s;
      !st_q.up && (st_q.cnt == $past(top) - 16'h0001);
   endsequence

   sequence down_at_bot_s;
      tick && dual && !st_q.up && at_bot;
   endsequence

   count_up_step_a: assert property (
      tick && dual && st_q.up && !at_top
      |=> st_q.up && (st_q.cnt == $past(st_q.cnt) + 16'h0001))
      else $error("counter did not step up by one");

   top_turn_a: assert property (up_at_top_s |=> turn_down_s)
      else $error("counter did not turn down after TOP");

   bottom_turn_a: assert property (
      down_at_bot_s |=> st_q.up && (st_q.cnt == 16'h0001))
      else $error("counter did not turn up after BOTTOM");

   idle_hold_a: assert property (
      !tick && dual |=> $stable(st_q.cnt) && $stable(st_q.cmp_a))
      else $error("counter moved without timer clock");

   ovf_bottom_a: assert property (
      tick && dual && at_bot |=> st_q.flags.ovf)
      else $error("overflow flag not set at BOTTOM");

   pc_load_a: assert property (
      tick && pc_mode && at_top |=> st_q.cmp_b == $past(st_q.buf_b))
      else $error("phase correct load missed at TOP");

   pfc_load_a: assert property (
      tick && pfc_mode && at_bot
      |=> (st_q.cmp_a == $past(st_q.buf_a)) && st_q.flags.ovf)
      else $error("frequency correct load missed at BOTTOM");

   match_flag_a: assert property (
      match_b |=> st_q.flags.cmp_b)
      else $error("compare flag not set on match");

   noninv_clear_a: assert property (
      match_a && (st_q.ctrl.mode_a == `DSPWM_COM_NONINV) &&
      st_q.up && !at_top && !at_bot |=> !st_q.pins.a_out)
      else $error("non-inverted output not cleared on up match");

   pin_hidden_a: assert property (
      !st_q.ctrl.dir_a |=> !st_q.pins.a_oe)
      else $error("pin driven with direction bit clear");

   cap_write_a: assert property (
      wr && (ofs == `DSPWM_CAP_TOP_OFS)
      |=> st_q.cap_top == $past(apb_req.pwdata[15:0]))
      else $error("capture top write not immediate");

   mask_write_a: assert property (
      wr && (ofs == `DSPWM_CMP_A_OFS) &&
      (st_q.ctrl.wave == `DSPWM_WAVE_PC_8)
      |=> st_q.buf_a[15:8] == 8'h00)
      else $error("compare bits above resolution not masked");

   inv_set_a: assert property (
      match_b && (st_q.ctrl.mode_b == `DSPWM_COM_INV) &&
      st_q.up && !at_top && !at_bot |=> st_q.pins.b_out)
      else $error("inverted output not set on up match");

   down_set_a: assert property (
      match_a && (st_q.ctrl.mode_a == `DSPWM_COM_NONINV) &&
      !st_q.up && !at_top && !at_bot |=> st_q.pins.a_out)
      else $error("non-inverted output not set on down match");

   toggle_flip_a: assert property (
      match_a && toggle_ok && (st_q.ctrl.mode_a == `DSPWM_COM_TOGGLE)
      |=> st_q.pins.a_out != $past(st_q.pins.a_out))
      else $error("toggle output did not flip on match");

   extreme_level_a: assert property (
      match_a && (st_q.ctrl.mode_a == `DSPWM_COM_NONINV) &&
      (at_top || at_bot) |=> st_q.pins.a_out == $past(at_top))
      else $error("extreme compare gave wrong level");

   cap_top_flag_a: assert property (
      tick && dual && at_top && top_is_cap(st_q.ctrl.wave)
      |=> st_q.flags.cap)
      else $error("capture flag not set at TOP");

   fixed_top_a: assert property (
      tick && st_q.up && (st_q.ctrl.wave == `DSPWM_WAVE_PC_8) &&
      (st_q.cnt == `DSPWM_TOP_8) |=> !st_q.up)
      else $error("8-bit fixed TOP did not turn the count");

endmodule

`default_nettype wire

// File: rtl/dspwm_regs.svh
`ifndef DSPWM_REGS_SVH
`define DSPWM_REGS_SVH

// register byte offsets on the apb bus
`define DSPWM_CTRL_OFS      12'h000
`define DSPWM_COUNT_OFS     12'h004
`define DSPWM_CMP_A_OFS     12'h008
`define DSPWM_CMP_B_OFS     12'h00c
`define DSPWM_CAP_TOP_OFS   12'h010
`define DSPWM_FLAGS_OFS     12'h014
`define DSPWM_STATUS_OFS    12'h018
`define DSPWM_OFS_W         12

// control word: wave[3:0] mode_a[5:4] mode_b[7:6] clk_sel[10:8]
// dir_a[11] dir_b[12]
`define DSPWM_CTRL_W        13
`define DSPWM_CTRL_RST      13'h0000
// flags word: ovf[0] cmp_a[1] cmp_b[2] cap[3], write one to clear
`define DSPWM_FLAGS_W       4
// status word: up[0] out_a[1] out_b[2]
`define DSPWM_STATUS_W      3

// waveform_mode_select codes of the dual-slope modes
`define DSPWM_WAVE_PC_8     4'h1
`define DSPWM_WAVE_PC_9     4'h2
`define DSPWM_WAVE_PC_10    4'h3
`define DSPWM_WAVE_PFC_CAP  4'h8
`define DSPWM_WAVE_PFC_CMPA 4'h9
`define DSPWM_WAVE_PC_CAP   4'ha
`define DSPWM_WAVE_PC_CMPA  4'hb

// fixed tops and resolution limits
`define DSPWM_TOP_8         16'h00ff
`define DSPWM_TOP_9         16'h01ff
`define DSPWM_TOP_10        16'h03ff
`define DSPWM_TOP_MIN       16'h0003
`define DSPWM_TOP_MAX       16'hffff
`define DSPWM_BOTTOM        16'h0000

// compare_output_mode codes
`define DSPWM_COM_OFF       2'h0
`define DSPWM_COM_TOGGLE    2'h1
`define DSPWM_COM_NONINV    2'h2
`define DSPWM_COM_INV       2'h3

// prescaler select codes and divider masks
`define DSPWM_CS_STOP       3'h0
`define DSPWM_CS_DIV1       3'h1
`define DSPWM_CS_DIV8       3'h2
`define DSPWM_CS_DIV64      3'h3
`define DSPWM_CS_DIV256     3'h4
`define DSPWM_CS_DIV1024    3'h5
`define DSPWM_PRESC_W       10
`define DSPWM_MASK_DIV1     10'h000
`define DSPWM_MASK_DIV8     10'h007
`define DSPWM_MASK_DIV64    10'h03f
`define DSPWM_MASK_DIV256   10'h0ff
`define DSPWM_MASK_DIV1024  10'h3ff

`endif

// File: rtl/dspwm_pkg.sv
`include "dspwm_regs.svh"

package dspwm_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } dspwm_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } dspwm_apb_rsp_type;

   typedef struct packed {
      logic a_out;
      logic a_oe;
      logic b_out;
      logic b_oe;
   } dspwm_pins_type;

   typedef struct packed {
      logic       dir_b;
      logic       dir_a;
      logic [2:0] clk_sel;
      logic [1:0] mode_b;
      logic [1:0] mode_a;
      logic [3:0] wave;
   } dspwm_ctrl_type;

   typedef struct packed {
      logic cap;
      logic cmp_b;
      logic cmp_a;
      logic ovf;
   } dspwm_flags_type;

   typedef struct packed {
      dspwm_ctrl_type    ctrl;
      dspwm_flags_type   flags;
      logic [15:0]       cnt;
      logic              up;
      logic [9:0]        presc;
      logic [15:0]       buf_a;
      logic [15:0]       buf_b;
      logic [15:0]       cmp_a;
      logic [15:0]       cmp_b;
      logic [15:0]       cap_top;
      dspwm_pins_type    pins;
      dspwm_apb_rsp_type rsp;
   } dspwm_state_type;

endpackage

// File: dv/dspwm_load.sv
`timescale 1ns/1ns
`default_nettype none

module dspwm_load (
   // pin drivers from the timer
   input  wire dspwm_pkg::dspwm_pins_type pins,
   // levels seen at the pads
   output logic                          pad_a,
   output logic                          pad_b
);
   // pads carry pull-downs: a released pad reads low, never a stale level
   assign pad_a = pins.a_oe ? pins.a_out : 1'b0;
   assign pad_b = pins.b_oe ? pins.b_out : 1'b0;
endmodule

`default_nettype wire

// File: dv/tb_dual_slope_pwm_timer.sv
`timescale 1ns/1ns
`include "dspwm_regs.svh"
`default_nettype none

module tb_dual_slope_pwm_timer;
   logic                         core_clk = 1'b0;
   logic                         rst = 1'b1;
   dspwm_pkg::dspwm_apb_req_type apb_req = '0;
   dspwm_pkg::dspwm_apb_rsp_type apb_rsp;
   dspwm_pkg::dspwm_pins_type    pins;
   logic                         pad_a;
   logic                         pad_b;
   logic [31:0]                  rd;
   logic                         rerr;
   int                           err_total = 0;
   int                           n_compared = 0;

   always #2 core_clk = ~core_clk;

   dspwm_timer DUT (
      .core_clk(core_clk),
      .rst     (rst),
      .apb_req (apb_req),
      .apb_rsp (apb_rsp),
      .pins    (pins)
   );

   dspwm_load LOAD (
      .pins (pins),
      .pad_a(pad_a),
      .pad_b(pad_b)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic do_rst;
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
   endtask

   // one full setup and access; an idle edge first keeps drives apart
   task automatic apb(input logic wr, input logic [11:0] ofs,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= wr;
      apb_req.paddr <= {20'h0, ofs};
      apb_req.pwdata <= wd;
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (apb_rsp.pready !== 1'b1);
      chk(n, 32'h1, "wait states");
      rd = apb_rsp.prdata;
      rerr = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic rdc(input logic [11:0] ofs, input logic [31:0] exp,
                      input string what);
      apb(1'b0, ofs, 32'h0);
      chk(rd, exp, what);
   endtask

   function automatic logic [31:0] ctl(input logic [3:0] w,
      input logic [1:0] ma, input logic [1:0] mb, input logic [2:0] cs,
      input logic da, input logic db);
      return {19'h0, db, da, cs, mb, ma, w};
   endfunction

   function automatic logic pv(input logic ch);
      return ch ? pad_b : pad_a;
   endfunction

   // second period is judged; the first may straddle a setting change
   task automatic pwm(input logic ch, input int eh, input int el);
      int n;
      int h;
      int l;
      repeat (2) begin
         n = 0;
         h = 0;
         l = 0;
         while (pv(ch) !== 1'b0 && n < 20000) begin
            @(posedge core_clk);
            n++;
         end
         while (pv(ch) !== 1'b1 && n < 20000) begin
            @(posedge core_clk);
            n++;
         end
         while (pv(ch) === 1'b1 && n < 20000) begin
            @(posedge core_clk);
            n++;
            h++;
         end
         while (pv(ch) === 1'b0 && n < 20000) begin
            @(posedge core_clk);
            n++;
            l++;
         end
      end
      chk(h, eh, "high time");
      chk(l, el, "low time");
   endtask

   task automatic steady(input logic ch, input logic v);
      int bad;
      bad = 0;
      repeat (24) begin
         @(posedge core_clk);
         if (pv(ch) !== v) begin
            bad++;
         end
      end
      chk(bad, 32'h0, "steady");
   endtask

   task automatic t_reset;
      do_rst();
      chk({28'h0, pins}, 32'h0, "pins");
      rdc(`DSPWM_CTRL_OFS, 32'h0, "ctrl");
      rdc(`DSPWM_COUNT_OFS, 32'h0, "count");
      rdc(`DSPWM_CMP_A_OFS, 32'h0, "cmp a");
      rdc(`DSPWM_CMP_B_OFS, 32'h0, "cmp b");
      rdc(`DSPWM_FLAGS_OFS, 32'h0, "flags");
      rdc(12'h01c, 32'h0, "unmapped");
      chk({31'h0, rerr}, 32'h1, "slverr");
      $display("t_reset done");
   endtask

   task automatic t_mask;
      do_rst();
      for (int w = 1; w < 4; w++) begin
         apb(1'b1, `DSPWM_CTRL_OFS, ctl(4'(w), 2'h0, 2'h0, 3'h0, 1'b0, 1'b0));
         apb(1'b1, `DSPWM_CMP_A_OFS, 32'h1234);
         rdc(`DSPWM_CMP_A_OFS, 32'h1234 & ((32'h80 << w) - 1), "mask");
      end
      apb(1'b1, `DSPWM_CTRL_OFS,
          ctl(`DSPWM_WAVE_PFC_CAP, 2'h0, 2'h0, 3'h0, 1'b0, 1'b0));
      apb(1'b1, `DSPWM_CMP_B_OFS, 32'h1234);
      rdc(`DSPWM_CMP_B_OFS, 32'h1234, "no mask");
      apb(1'b1, `DSPWM_CAP_TOP_OFS, 32'hbeef);
      rdc(`DSPWM_CAP_TOP_OFS, 32'hbeef, "cap top");
      $display("t_mask done");
   endtask

   task automatic t_fixed;
      int top;
      for (int w = 1; w < 4; w++) begin
         top = (256 << (w - 1)) - 1;
         do_rst();
         apb(1'b1, `DSPWM_CTRL_OFS, ctl(4'(w), 2'h0, 2'h0, 3'h0, 1'b0, 1'b0));
         apb(1'b1, `DSPWM_CMP_A_OFS, 32'h10);
         apb(1'b1, `DSPWM_CMP_B_OFS, 32'h10);
         apb(1'b1, `DSPWM_CTRL_OFS, ctl(4'(w), `DSPWM_COM_NONINV,
             `DSPWM_COM_INV, `DSPWM_CS_DIV1, 1'b1, 1'b1));
         pwm(1'b0, 32, 2 * (top - 16));
         pwm(1'b1, 2 * (top - 16), 32);
      end
      $display("t_fixed done");
   endtask

   task automatic t_presc;
      int nv[5] = '{1, 8, 64, 256, 1024};
      for (int i = 0; i < 5; i++) begin
         do_rst();
         apb(1'b1, `DSPWM_CAP_TOP_OFS, 32'h3);
         apb(1'b1, `DSPWM_CMP_A_OFS, 32'h1);
         apb(1'b1, `DSPWM_CTRL_OFS, ctl(`DSPWM_WAVE_PFC_CAP,
             `DSPWM_COM_NONINV, 2'h0, 3'(i + 1), 1'b1, 1'b0));
         pwm(1'b0, 2 * nv[i], 4 * nv[i]);
      end
      $display("t_presc done");
   endtask

   task automatic t_extreme;
      do_rst();
      apb(1'b1, `DSPWM_CAP_TOP_OFS, 32'h5);
      for (int c = 0; c < 6; c += 5) begin
         apb(1'b1, `DSPWM_CMP_A_OFS, 32'(c));
         apb(1'b1, `DSPWM_CMP_B_OFS, 32'(c));
         apb(1'b1, `DSPWM_CTRL_OFS, ctl(`DSPWM_WAVE_PFC_CAP,
             `DSPWM_COM_NONINV, `DSPWM_COM_INV, `DSPWM_CS_DIV1, 1'b1, 1'b1));
         repeat (30) @(posedge core_clk);
         steady(1'b0, c != 0);
         steady(1'b1, c == 0);
      end
      apb(1'b0, `DSPWM_STATUS_OFS, 32'h0);
      chk(rd & 32'h6, 32'h2, "status");
      $display("t_extreme done");
   endtask

   task automatic t_toggle;
      logic [3:0] wv[2] = '{`DSPWM_WAVE_PFC_CMPA, `DSPWM_WAVE_PC_CMPA};
      for (int i = 0; i < 2; i++) begin
         do_rst();
         apb(1'b1, `DSPWM_CMP_A_OFS, 32'h5);
         apb(1'b1, `DSPWM_CTRL_OFS, ctl(wv[i], `DSPWM_COM_TOGGLE,
             `DSPWM_COM_TOGGLE, `DSPWM_CS_DIV1, 1'b1, 1'b1));
         pwm(1'b0, 10, 10);
         chk({31'h0, pins.b_oe}, 32'h0, "b off");
      end
      $display("t_toggle done");
   endtask

   task automatic t_flags;
      logic [3:0]  wv[2] = '{`DSPWM_WAVE_PFC_CAP, `DSPWM_WAVE_PC_CAP};
      logic [31:0] c0;
      for (int i = 0; i < 2; i++) begin
         do_rst();
         apb(1'b1, `DSPWM_CAP_TOP_OFS, 32'h5);
         apb(1'b1, `DSPWM_CMP_A_OFS, 32'h2);
         apb(1'b1, `DSPWM_CMP_B_OFS, 32'h4);
         apb(1'b1, `DSPWM_CTRL_OFS, ctl(wv[i], `DSPWM_COM_NONINV, 2'h0,
             `DSPWM_CS_DIV1, 1'b0, 1'b0));
         repeat (30) @(posedge core_clk);
         chk({31'h0, pad_a}, 32'h0, "pad off");
         chk({31'h0, pins.a_oe}, 32'h0, "oe off");
         apb(1'b1, `DSPWM_CTRL_OFS, ctl(wv[i], `DSPWM_COM_NONINV, 2'h0,
             `DSPWM_CS_STOP, 1'b0, 1'b0));
         rdc(`DSPWM_FLAGS_OFS, 32'hf, "flags");
         apb(1'b1, `DSPWM_FLAGS_OFS, 32'hf);
         rdc(`DSPWM_FLAGS_OFS, 32'h0, "cleared");
         apb(1'b0, `DSPWM_COUNT_OFS, 32'h0);
         c0 = rd;
         repeat (8) @(posedge core_clk);
         rdc(`DSPWM_COUNT_OFS, c0, "frozen");
      end
      $display("t_flags done");
   endtask

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      t_reset();
      t_mask();
      t_fixed();
      t_presc();
      t_extreme();
      t_toggle();
      t_flags();
      wrap_up();
   end

   initial begin
      repeat (95000) @(posedge core_clk);
      err_total++;
      $display("BAD %0t watchdog expired", $time);
      wrap_up();
   end
endmodule

`default_nettype wire
